//--- logic/esrcu_params.svh
`ifndef ESRCU_PARAMS_SVH
`define ESRCU_PARAMS_SVH

// ****************************************************************
// Event bit positions
// ****************************************************************
`define ESRCU_EVT_SYS_FAULT 0
`define ESRCU_EVT_NO_MEAS 1
`define ESRCU_EVT_USED_BITS 10
`define ESRCU_FLT_SELF_TEST 15

// ****************************************************************
// Reset values
// ****************************************************************
`define ESRCU_MASK_RST 16'h0000
`define ESRCU_TERM0_RST 8'h0D
`define ESRCU_TERM1_RST 8'h0A
`define ESRCU_TERM_LEN_RST 2'h2
`define ESRCU_BAUD_RST 3'h2
`define ESRCU_UART_EN_RST 1'h1
`define ESRCU_MODE_RST 2'h1
`define ESRCU_CTYPE_RST 2'h1

// ****************************************************************
// Codes
// ****************************************************************
`define ESRCU_ERR_MODE 8'h0B
`define ESRCU_ERR_NO_SUPPLY 8'h12
`define ESRCU_ERR_UNITS 8'h7F
`define ESRCU_ERR_RANGE 8'h0A
`define ESRCU_ERR_OVERFLOW 8'hFE
`define ESRCU_ERR_DEPTH 20
`define ESRCU_BAUD_MAX 3'h6
`define ESRCU_FORCE_NONE 2'h0
`define ESRCU_FORCE_OFF 2'h1
`define ESRCU_FORCE_ON 2'h2
`define ESRCU_MODE_BINARY 2'h1
`define ESRCU_MODE_PURITY 2'h2
`define ESRCU_MODE_PHYS 2'h3
`define ESRCU_CTYPE_MOLE 2'h1
`define ESRCU_CTYPE_MASS 2'h2
`define ESRCU_OVERLOAD 32'h7E94F578

`endif

//--- logic/esrcu_pkg.sv
package esrcu_pkg;

  typedef enum logic [4:0] {
    OP_NONE, OP_FLT_HELD_Q, OP_FLT_NOW_Q, OP_FLT_MASK_SET, OP_FLT_MASK_Q,
    OP_EVT_HELD_Q, OP_EVT_NOW_Q, OP_EVT_MASK_SET, OP_EVT_MASK_Q,
    OP_RCFG_SET, OP_RCFG_Q, OP_RFORCE_SET, OP_RFORCE_Q, OP_RPOS_Q,
    OP_BAUD_SET, OP_BAUD_Q, OP_UEN_SET, OP_UEN_Q, OP_TERM_SET, OP_ERR_POP,
    OP_MODE_SET, OP_MODE_Q, OP_CTYPE_SET, OP_CTYPE_Q,
    OP_NORMALIZED_SOUND_SPEED_QUERY_Q, OP_CELL_PRESSURE_QUERY_Q, OP_PURITY_RESULT_QUERY_Q, OP_GAS_RATIO_QUERY_Q
  } esrcu_op_t;

  // Unit suffix: none means the global unit applies
  typedef enum logic [2:0] {
    UNIT_NONE, UNIT_RATIO, UNIT_SPEED, UNIT_PRESSURE, UNIT_TEMP
  } esrcu_unit_t;

  typedef struct packed {
    esrcu_op_t op;
    logic has_idx;
    logic [7:0] idx;
    logic [31:0] val;
    esrcu_unit_t unit;
  } esrcu_cmd_t;

  typedef struct packed {
    logic [31:0] data;
    logic [7:0] err;
    esrcu_unit_t unit;
  } esrcu_rsp_t;

  typedef struct packed {
    logic [31:0] normalized_sound_speed_query;
    logic [31:0] cell_pressure_query;
    logic [31:0] purity_result_query;
    logic [31:0] gas_ratio_query_mole_1;
    logic [31:0] gas_ratio_query_mole_2;
    logic [31:0] gas_ratio_query_mass_1;
    logic [31:0] gas_ratio_query_mass_2;
    logic [3:0] bad;
  } esrcu_meas_t;

endpackage : esrcu_pkg

//--- logic/esrcu_core.sv
`timescale 1ns/1ns
`include "esrcu_params.svh"
// Contract
// - Held fault bits set whenever the matching live fault bit is set; stay until cleared.
// - Querying held fault register clears it entirely.
// - Status query with bit index 0..15 returns only that bit.
// - Two relay config masks, index 1 or 2, event layout, no status effect.
// - Relay on when any event chosen by its config mask is active.
// - Event summary bit set when enable mask meets held event bits.
// - Live event query returns instantaneous bits, unlatched.
// - Event bit layout: faults, no measurement, limits; bits 10-15 reserved.
// - Held event register captures every live event bit that sets.
// - Querying held event register clears it entirely.
// - Relay force: 0 event control, 1 forced off, 2 forced on.
// - Force setting stored without relay supply; relay inert until supply returns.
// - Relay position query gives 0 or 1; error 18 without supply.
// - Baud code per interface, codes 0..6 for 2400..115200 baud.
// - Error pop returns newest stored code and removes it; depth 20.
// - Beyond 19 unread errors, store 254 as twentieth entry.
// - Per-interface enable; value 1 enables, anything else disables.
// - Up to three terminator bytes on responses; reset gives 13 then 10.
// - Measurement query invalid for current mode raises error 11.
// - Faulty measurement answers overload value 9.9E37.
// - Wrong unit family raises error 127; omitted unit means global unit.
// - Ratio query picks gas 1 or 2, mole or mass; binary mode only.
// - Fault summary bit set when fault mask meets held fault bits.
// - Mode codes: 1 binary, 2 purity, 3 physical.
// - Concentration type: 1 mole fraction, 2 mass fraction.
module esrcu_core #(
  parameter int ERR_DEPTH = `ESRCU_ERR_DEPTH
) (
  input wire logic mclk, // 250 MHz clock
  input wire logic rst, // Synchronous reset, high
  input wire logic cmd_valid, // Decoded command present
  input wire esrcu_pkg::esrcu_cmd_t cmd, // Decoded command
  output logic rsp_valid, // One-cycle response strobe
  output esrcu_pkg::esrcu_rsp_t rsp, // Response value and error
  input wire logic [15:0] fault_pin, // Live fault conditions, async
  input wire logic [15:0] event_pin, // Live event conditions, async
  input wire logic supply_pin, // Relay supply present, async
  input wire esrcu_pkg::esrcu_meas_t meas, // Measurement results, same clock
  output logic [1:0] relay_drive, // Relay coil drive
  output logic fault_summary_bit, // Status byte fault summary
  output logic event_summary_bit, // Status byte event summary
  output logic [5:0] baud_code, // Baud code, 3 bits per interface
  output logic [1:0] uart_enable, // Serial interface enables
  output logic [23:0] term_bytes, // Terminator bytes, first in low byte
  output logic [1:0] term_len, // Terminator byte count
  output logic [1:0] instrument_mode // Current instrument mode
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [32:0] sync1_r, sync2_r, sync3_r, live_r;
  logic [32:0] pins;
  assign pins = {supply_pin, event_pin, fault_pin};

  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // A change counts only once two stages agree, which rejects single-cycle glitches
  genvar g;
  generate
    for (g = 0; g < 33; g++) begin : g_live
      always_ff @(posedge mclk) begin
        if (rst) begin
          live_r[g] <= 1'b0;
        end else if (sync2_r[g] == sync3_r[g]) begin
          live_r[g] <= sync2_r[g];
        end
      end
    end
  endgenerate

  logic [15:0] fault_now, event_now;
  logic supply_ok;
  assign fault_now = live_r[15:0];
  assign event_now = {6'h00, live_r[16 +: `ESRCU_EVT_USED_BITS]};
  assign supply_ok = live_r[32];

  // ****************************************************************
  // Command decode helpers
  // ****************************************************************
  function automatic logic [31:0] status_read(input logic [15:0] v, input logic has_idx,
                                              input logic [7:0] idx);
    if (has_idx) begin
      status_read = {31'h0, v[idx[3:0]]};
    end else begin
      status_read = {16'h0, v};
    end
  endfunction : status_read

  function automatic logic relay_sel_ok(input logic [31:0] v);
    relay_sel_ok = (v[31:8] == 24'h0) && (v[7:0] == 8'h01 || v[7:0] == 8'h02);
  endfunction : relay_sel_ok

  logic go;
  logic idx_bad;
  assign go = cmd_valid;
  assign idx_bad = cmd.has_idx && (cmd.idx > 8'h0F);

  // ****************************************************************
  // Latched status registers
  // ****************************************************************
  logic [15:0] fault_status_held_r, event_status_held_r;
  logic clr_fault, clr_event;
  assign clr_fault = go && cmd.op == esrcu_pkg::OP_FLT_HELD_Q && !idx_bad;
  assign clr_event = go && cmd.op == esrcu_pkg::OP_EVT_HELD_Q && !idx_bad;

  // A condition live in the clearing cycle survives: set wins over clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_status_held_r <= 16'h0000;
    end else begin
      fault_status_held_r <= (clr_fault ? 16'h0000 : fault_status_held_r) | fault_now;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      event_status_held_r <= 16'h0000;
    end else begin
      event_status_held_r <= (clr_event ? 16'h0000 : event_status_held_r) | event_now;
    end
  end

  // ****************************************************************
  // Masks and settings
  // ****************************************************************
  logic [15:0] fault_summary_mask_r, event_summary_mask_r;
  logic [15:0] relay_one_config_mask_r, relay_two_config_mask_r;
  logic [1:0] force_r [2];
  logic [2:0] baud_r [2];
  logic [1:0] uen_r;
  logic [7:0] term_r [3];
  logic [1:0] term_len_r;
  logic [1:0] mode_r, ctype_r;
  logic sel_two;
  logic [31:0] setv;
  assign sel_two = cmd.idx == 8'h02;
  assign setv = cmd.val;

  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_summary_mask_r <= `ESRCU_MASK_RST;
      event_summary_mask_r <= `ESRCU_MASK_RST;
    end else if (go && cmd.op == esrcu_pkg::OP_FLT_MASK_SET) begin
      fault_summary_mask_r <= setv[15:0];
    end else if (go && cmd.op == esrcu_pkg::OP_EVT_MASK_SET) begin
      event_summary_mask_r <= setv[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      relay_one_config_mask_r <= `ESRCU_MASK_RST;
      relay_two_config_mask_r <= `ESRCU_MASK_RST;
    end else if (go && cmd.op == esrcu_pkg::OP_RCFG_SET && relay_sel_ok({24'h0, cmd.idx})) begin
      if (sel_two) begin
        relay_two_config_mask_r <= setv[15:0];
      end else begin
        relay_one_config_mask_r <= setv[15:0];
      end
    end
  end

  // Stored regardless of supply; only the drive stage and the position query look at the supply
  always_ff @(posedge mclk) begin
    if (rst) begin
      force_r[0] <= `ESRCU_FORCE_NONE;
      force_r[1] <= `ESRCU_FORCE_NONE;
    end else if (go && cmd.op == esrcu_pkg::OP_RFORCE_SET && relay_sel_ok({24'h0, cmd.idx})
                 && setv <= 32'h2) begin
      force_r[sel_two] <= setv[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      baud_r[0] <= `ESRCU_BAUD_RST;
      baud_r[1] <= `ESRCU_BAUD_RST;
      uen_r <= {2{`ESRCU_UART_EN_RST}};
    end else if (go && cmd.idx <= 8'h01) begin
      if (cmd.op == esrcu_pkg::OP_BAUD_SET && setv <= {29'h0, `ESRCU_BAUD_MAX}) begin
        baud_r[cmd.idx[0]] <= setv[2:0];
      end else if (cmd.op == esrcu_pkg::OP_UEN_SET) begin
        uen_r[cmd.idx[0]] <= (setv == 32'h1);
      end
    end
  end

  // Terminator bytes arrive packed in the value, count in the index
  always_ff @(posedge mclk) begin
    if (rst) begin
      term_r[0] <= `ESRCU_TERM0_RST;
      term_r[1] <= `ESRCU_TERM1_RST;
      term_r[2] <= 8'h00;
      term_len_r <= `ESRCU_TERM_LEN_RST;
    end else if (go && cmd.op == esrcu_pkg::OP_TERM_SET && cmd.idx >= 8'h01
                 && cmd.idx <= 8'h03) begin
      term_r[0] <= setv[7:0];
      term_r[1] <= setv[15:8];
      term_r[2] <= setv[23:16];
      term_len_r <= cmd.idx[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_r <= `ESRCU_MODE_RST;
      ctype_r <= `ESRCU_CTYPE_RST;
    end else if (go && setv >= 32'h1 && setv <= {30'h0, `ESRCU_MODE_PHYS}) begin
      if (cmd.op == esrcu_pkg::OP_MODE_SET) begin
        mode_r <= setv[1:0];
      end else if (cmd.op == esrcu_pkg::OP_CTYPE_SET && setv <= {30'h0, `ESRCU_CTYPE_MASS}) begin
        ctype_r <= setv[1:0];
      end
    end
  end

  // ****************************************************************
  // Relays and status byte
  // ****************************************************************
  logic [1:0] relay_on;
  logic [15:0] cfg_mask [2];
  assign cfg_mask[0] = relay_one_config_mask_r;
  assign cfg_mask[1] = relay_two_config_mask_r;

  generate
    for (g = 0; g < 2; g++) begin : g_relay
      always_comb begin
        case (force_r[g])
          `ESRCU_FORCE_ON: relay_on[g] = 1'b1;
          `ESRCU_FORCE_OFF: relay_on[g] = 1'b0;
          default: relay_on[g] = |(cfg_mask[g] & event_now);
        endcase
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (rst) begin
      relay_drive <= 2'b00;
    end else begin
      relay_drive <= supply_ok ? relay_on : 2'b00;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_summary_bit <= 1'b0;
      event_summary_bit <= 1'b0;
    end else begin
      fault_summary_bit <= |(fault_summary_mask_r & fault_status_held_r);
      event_summary_bit <= |(event_summary_mask_r & event_status_held_r);
    end
  end

  // ****************************************************************
  // Answer and error selection
  // ****************************************************************
  logic [31:0] ans;
  logic [7:0] err;
  logic [7:0] err_top;
  logic [4:0] err_cnt_r;

  always_comb begin
    ans = 32'h0;
    err = 8'h00;
    case (cmd.op)
      esrcu_pkg::OP_FLT_HELD_Q: ans = status_read(fault_status_held_r, cmd.has_idx, cmd.idx);
      esrcu_pkg::OP_FLT_NOW_Q: ans = status_read(fault_now, cmd.has_idx, cmd.idx);
      esrcu_pkg::OP_EVT_HELD_Q: ans = status_read(event_status_held_r, cmd.has_idx, cmd.idx);
      esrcu_pkg::OP_EVT_NOW_Q: ans = status_read(event_now, cmd.has_idx, cmd.idx);
      esrcu_pkg::OP_FLT_MASK_Q: ans = {16'h0, fault_summary_mask_r};
      esrcu_pkg::OP_EVT_MASK_Q: ans = {16'h0, event_summary_mask_r};
      esrcu_pkg::OP_RCFG_Q: ans = {16'h0, cfg_mask[sel_two]};
      esrcu_pkg::OP_RFORCE_Q: ans = {30'h0, force_r[sel_two]};
      esrcu_pkg::OP_RPOS_Q: begin
        if (!supply_ok) begin
          err = `ESRCU_ERR_NO_SUPPLY;
        end else begin
          ans = {31'h0, relay_on[sel_two]};
        end
      end
      esrcu_pkg::OP_BAUD_Q: ans = {29'h0, baud_r[cmd.idx[0]]};
      esrcu_pkg::OP_UEN_Q: ans = {31'h0, uen_r[cmd.idx[0]]};
      esrcu_pkg::OP_MODE_Q: ans = {30'h0, mode_r};
      esrcu_pkg::OP_CTYPE_Q: ans = {30'h0, ctype_r};
      esrcu_pkg::OP_ERR_POP: ans = {24'h0, err_top};
      esrcu_pkg::OP_NORMALIZED_SOUND_SPEED_QUERY_Q: begin
        if (cmd.unit != esrcu_pkg::UNIT_NONE && cmd.unit != esrcu_pkg::UNIT_SPEED) begin
          err = `ESRCU_ERR_UNITS;
        end else begin
          ans = meas.bad[0] ? `ESRCU_OVERLOAD : meas.normalized_sound_speed_query;
        end
      end
      esrcu_pkg::OP_CELL_PRESSURE_QUERY_Q: begin
        if (cmd.unit != esrcu_pkg::UNIT_NONE && cmd.unit != esrcu_pkg::UNIT_PRESSURE) begin
          err = `ESRCU_ERR_UNITS;
        end else begin
          ans = meas.bad[1] ? `ESRCU_OVERLOAD : meas.cell_pressure_query;
        end
      end
      esrcu_pkg::OP_PURITY_RESULT_QUERY_Q: begin
        if (mode_r != `ESRCU_MODE_PURITY) begin
          err = `ESRCU_ERR_MODE;
        end else if (cmd.unit != esrcu_pkg::UNIT_NONE && cmd.unit != esrcu_pkg::UNIT_RATIO) begin
          err = `ESRCU_ERR_UNITS;
        end else begin
          ans = meas.bad[2] ? `ESRCU_OVERLOAD : meas.purity_result_query;
        end
      end
      esrcu_pkg::OP_GAS_RATIO_QUERY_Q: begin
        if (mode_r != `ESRCU_MODE_BINARY) begin
          err = `ESRCU_ERR_MODE;
        end else if (cmd.unit != esrcu_pkg::UNIT_NONE && cmd.unit != esrcu_pkg::UNIT_RATIO) begin
          err = `ESRCU_ERR_UNITS;
        end else if (!relay_sel_ok({24'h0, cmd.idx})) begin
          err = `ESRCU_ERR_RANGE;
        end else if (meas.bad[3]) begin
          ans = `ESRCU_OVERLOAD;
        end else if (ctype_r == `ESRCU_CTYPE_MASS) begin
          ans = sel_two ? meas.gas_ratio_query_mass_2 : meas.gas_ratio_query_mass_1;
        end else begin
          ans = sel_two ? meas.gas_ratio_query_mole_2 : meas.gas_ratio_query_mole_1;
        end
      end
      default: ans = 32'h0;
    endcase
    // Out-of-range arguments are refused before any effect
    if ((cmd.op == esrcu_pkg::OP_FLT_HELD_Q || cmd.op == esrcu_pkg::OP_FLT_NOW_Q
         || cmd.op == esrcu_pkg::OP_EVT_HELD_Q || cmd.op == esrcu_pkg::OP_EVT_NOW_Q) && idx_bad) begin
      err = `ESRCU_ERR_RANGE;
    end
    if ((cmd.op == esrcu_pkg::OP_RCFG_Q || cmd.op == esrcu_pkg::OP_RFORCE_Q
         || cmd.op == esrcu_pkg::OP_RPOS_Q) && !relay_sel_ok({24'h0, cmd.idx})) begin
      err = `ESRCU_ERR_RANGE;
    end
    if (err != 8'h00) begin
      ans = 32'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      rsp_valid <= go && cmd.op != esrcu_pkg::OP_NONE;
      rsp.data <= ans;
      rsp.err <= err;
      rsp.unit <= cmd.unit;
    end
  end

  // ****************************************************************
  // Error stack
  // ****************************************************************
  logic [7:0] err_mem [ERR_DEPTH];
  logic push, pop;
  assign push = go && err != 8'h00;
  assign pop = go && cmd.op == esrcu_pkg::OP_ERR_POP && err_cnt_r != 5'h00;
  assign err_top = (err_cnt_r == 5'h00) ? 8'h00 : err_mem[err_cnt_r - 5'h01];

  // Once full, the last slot already reads as the overflow mark; more are dropped
  always_ff @(posedge mclk) begin
    if (push && err_cnt_r < 5'(ERR_DEPTH)) begin
      err_mem[err_cnt_r] <= (err_cnt_r == 5'(ERR_DEPTH - 1)) ? `ESRCU_ERR_OVERFLOW : err;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      err_cnt_r <= 5'h00;
    end else if (pop) begin
      err_cnt_r <= err_cnt_r - 5'h01;
    end else if (push && err_cnt_r < 5'(ERR_DEPTH)) begin
      err_cnt_r <= err_cnt_r + 5'h01;
    end
  end

  assign baud_code = {baud_r[1], baud_r[0]};
  assign uart_enable = uen_r;
  assign term_bytes = {term_r[2], term_r[1], term_r[0]};
  assign term_len = term_len_r;
  assign instrument_mode = mode_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_held_query;
    go && cmd.op == esrcu_pkg::OP_FLT_HELD_Q && !idx_bad;
  endsequence

  fault_latch_a: assert property (|(fault_now & ~$past(fault_now)) ##0 1'b1
    |=> ((fault_status_held_r & $past(fault_now)) == $past(fault_now)))
    else $error("fault bit not latched");
  fault_clear_a: assert property (s_held_query |=> fault_status_held_r == $past(fault_now))
    else $error("held faults not cleared on query");
  event_clear_a: assert property (clr_event |=> event_status_held_r == $past(event_now))
    else $error("held events not cleared on query");
  event_hold_a: assert property (!clr_event |=> (event_status_held_r & $past(event_status_held_r))
    == $past(event_status_held_r))
    else $error("held event bit lost");
  relay_force_a: assert property (force_r[0] == `ESRCU_FORCE_ON && supply_ok
    |=> relay_drive[0])
    else $error("forced relay not on");
  relay_supply_a: assert property (!supply_ok |=> relay_drive == 2'b00)
    else $error("relay driven without supply");
  relay_pos_a: assert property (go && cmd.op == esrcu_pkg::OP_RPOS_Q && !supply_ok
    && relay_sel_ok({24'h0, cmd.idx})
    |=> rsp_valid && rsp.err == `ESRCU_ERR_NO_SUPPLY)
    else $error("no supply error missing");
  mode_check_a: assert property (go && cmd.op == esrcu_pkg::OP_GAS_RATIO_QUERY_Q
    && mode_r != `ESRCU_MODE_BINARY |=> rsp.err == `ESRCU_ERR_MODE)
    else $error("illegal mode not refused");
  overflow_mark_a: assert property (push && err_cnt_r == 5'(ERR_DEPTH - 1)
    |=> err_top == `ESRCU_ERR_OVERFLOW && err_cnt_r == 5'(ERR_DEPTH))
    else $error("overflow mark not stored");
  summary_evt_a: assert property (|(event_summary_mask_r & event_status_held_r)
    |=> event_summary_bit)
    else $error("event summary missing");
  bit_query_a: assert property (go && cmd.op == esrcu_pkg::OP_EVT_NOW_Q && cmd.has_idx
    && !idx_bad |=> rsp.data[31:1] == 31'h0)
    else $error("single bit query too wide");

endmodule : esrcu_core

//--- verification/esrcu_host.sv
`timescale 1ns/1ns
// ****************************************************************
// Host side: one decoded command per call, answer taken one cycle on
// ****************************************************************
module esrcu_host (
  input wire logic mclk, // Clock
  output logic cmd_valid, // Command strobe
  output esrcu_pkg::esrcu_cmd_t cmd, // Command
  input wire logic rsp_valid, // Response strobe
  input wire esrcu_pkg::esrcu_rsp_t rsp // Response
);
  esrcu_pkg::esrcu_rsp_t got; // Last answer taken
  logic got_ok; // Answer strobe seen in its cycle
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
    got = '0;
    got_ok = 1'b0;
  end
  // Strobe stays one cycle, so the answer is read at the next falling edge
  task automatic send(input esrcu_pkg::esrcu_op_t op, input logic hi, input logic [7:0] ix,
      input logic [31:0] v, input esrcu_pkg::esrcu_unit_t u);
    @(negedge mclk);
    cmd = '{op, hi, ix, v, u};
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd = '0;
    got_ok = rsp_valid;
    got = rsp;
  endtask : send
endmodule : esrcu_host

//--- verification/event_status_relay_command_unit_tb.sv
`timescale 1ns/1ns
module event_status_relay_command_unit_tb;
  typedef struct {esrcu_pkg::esrcu_op_t op; logic [7:0] ix; logic [31:0] v;
    esrcu_pkg::esrcu_unit_t u; logic [31:0] d; logic [7:0] e;} esrcu_row_t;
  localparam esrcu_pkg::esrcu_unit_t un = esrcu_pkg::UNIT_NONE;
  logic mclk = 1'b0, rst = 1'b1, cmd_valid, rsp_valid, supply_pin = 1'b1;
  logic fault_summary_bit, event_summary_bit;
  esrcu_pkg::esrcu_cmd_t cmd;
  esrcu_pkg::esrcu_rsp_t rsp;
  esrcu_pkg::esrcu_meas_t meas;
  logic [15:0] fault_pin = 16'h0000, event_pin = 16'h0000;
  logic [1:0] relay_drive, uart_enable, term_len, instrument_mode;
  logic [5:0] baud_code;
  logic [23:0] term_bytes;
  int fail_count = 0, cmp_count = 0, cyc = 0;
  esrcu_row_t rows [23];
  always #2 mclk = ~mclk;
  esrcu_host h (.mclk(mclk), .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp));
  esrcu_core #(.ERR_DEPTH(20)) dut (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp(rsp), .fault_pin(fault_pin), .event_pin(event_pin),
    .supply_pin(supply_pin), .meas(meas), .relay_drive(relay_drive),
    .fault_summary_bit(fault_summary_bit), .event_summary_bit(event_summary_bit),
    .baud_code(baud_code), .uart_enable(uart_enable), .term_bytes(term_bytes),
    .term_len(term_len), .instrument_mode(instrument_mode));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk_rsp(input logic [31:0] d, input logic [7:0] e);
    cmp_count++;
    if (h.got_ok !== 1'b1 || h.got.data !== d || h.got.err !== e) begin
      fail_count++;
      $display("unexpected at %0t: answer %h/%h, wanted %h/%h", $time, h.got.data, h.got.err, d, e);
    end
  endtask : chk_rsp
  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: output %h, wanted %h", $time, got, exp);
    end
  endtask : chk_pin
  task automatic q(input esrcu_pkg::esrcu_op_t op, input logic hi, input logic [7:0] ix,
      input logic [31:0] v, input logic [31:0] d, input logic [7:0] e);
    h.send(op, hi, ix, v, un);
    chk_rsp(d, e);
  endtask : q
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask : w
  // Hang guard: the whole run needs well under two thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    meas = '{32'h11, 32'h22, 32'h33, 32'h41, 32'h42, 32'h43, 32'h44, 4'h0};
    rows = '{
      '{esrcu_pkg::OP_BAUD_Q, 8'h0, 32'h0, un, 32'h2, 8'h0},
      '{esrcu_pkg::OP_BAUD_SET, 8'h1, 32'h6, un, 32'h0, 8'h0},
      '{esrcu_pkg::OP_BAUD_Q, 8'h1, 32'h0, un, 32'h6, 8'h0},
      '{esrcu_pkg::OP_UEN_SET, 8'h0, 32'h2, un, 32'h0, 8'h0},
      '{esrcu_pkg::OP_UEN_Q, 8'h0, 32'h0, un, 32'h0, 8'h0},
      '{esrcu_pkg::OP_EVT_MASK_SET, 8'h0, 32'h3, un, 32'h0, 8'h0},
      '{esrcu_pkg::OP_EVT_MASK_Q, 8'h0, 32'h0, un, 32'h3, 8'h0},
      '{esrcu_pkg::OP_RCFG_SET, 8'h1, 32'h3, un, 32'h0, 8'h0},
      '{esrcu_pkg::OP_RCFG_Q, 8'h1, 32'h0, un, 32'h3, 8'h0},
      '{esrcu_pkg::OP_RCFG_SET, 8'h2, 32'h4, un, 32'h0, 8'h0},
      '{esrcu_pkg::OP_RCFG_Q, 8'h2, 32'h0, un, 32'h4, 8'h0},
      '{esrcu_pkg::OP_FLT_MASK_Q, 8'h0, 32'h0, un, 32'h0, 8'h0},
      '{esrcu_pkg::OP_CELL_PRESSURE_QUERY_Q, 8'h0, 32'h0, esrcu_pkg::UNIT_PRESSURE, 32'h22, 8'h0},
      '{esrcu_pkg::OP_NORMALIZED_SOUND_SPEED_QUERY_Q, 8'h0, 32'h0, esrcu_pkg::UNIT_PRESSURE, 32'h0, 8'h7F},
      '{esrcu_pkg::OP_NORMALIZED_SOUND_SPEED_QUERY_Q, 8'h0, 32'h0, un, 32'h11, 8'h0},
      '{esrcu_pkg::OP_PURITY_RESULT_QUERY_Q, 8'h0, 32'h0, un, 32'h0, 8'h0B},
      '{esrcu_pkg::OP_GAS_RATIO_QUERY_Q, 8'h1, 32'h0, un, 32'h41, 8'h0},
      '{esrcu_pkg::OP_CTYPE_SET, 8'h0, 32'h2, un, 32'h0, 8'h0},
      '{esrcu_pkg::OP_GAS_RATIO_QUERY_Q, 8'h2, 32'h0, un, 32'h44, 8'h0},
      '{esrcu_pkg::OP_CTYPE_Q, 8'h0, 32'h0, un, 32'h2, 8'h0},
      '{esrcu_pkg::OP_MODE_SET, 8'h0, 32'h2, un, 32'h0, 8'h0},
      '{esrcu_pkg::OP_MODE_Q, 8'h0, 32'h0, un, 32'h2, 8'h0},
      '{esrcu_pkg::OP_PURITY_RESULT_QUERY_Q, 8'h0, 32'h0, esrcu_pkg::UNIT_RATIO, 32'h33, 8'h0}};
    w(3);
    rst = 1'b0;
    chk_pin({term_len, term_bytes}, {6'h0, 2'h2, 24'h000A0D});
    chk_pin({instrument_mode, uart_enable, baud_code}, {22'h0, 2'h1, 2'h3, 6'h12});
    foreach (rows[i]) begin
      h.send(rows[i].op, 1'b0, rows[i].ix, rows[i].v, rows[i].u);
      chk_rsp(rows[i].d, rows[i].e);
    end
    q(esrcu_pkg::OP_GAS_RATIO_QUERY_Q, 1'b0, 8'h1, 32'h0, 32'h0, 8'h0B);
    q(esrcu_pkg::OP_MODE_SET, 1'b0, 8'h0, 32'h1, 32'h0, 8'h0);
    // ****************************************************************
    // Latching, relays, supply loss, terminator, error stack
    // ****************************************************************
    event_pin = 16'h0004;
    w(8);
    chk_pin(relay_drive, 32'h2);
    event_pin = 16'h0000;
    w(8);
    q(esrcu_pkg::OP_EVT_NOW_Q, 1'b0, 8'h0, 32'h0, 32'h0, 8'h0);
    chk_pin(event_summary_bit, 32'h0);
    q(esrcu_pkg::OP_EVT_HELD_Q, 1'b0, 8'h0, 32'h0, 32'h4, 8'h0);
    q(esrcu_pkg::OP_EVT_HELD_Q, 1'b0, 8'h0, 32'h0, 32'h0, 8'h0);
    event_pin = 16'h0001;
    w(8);
    chk_pin({relay_drive, event_summary_bit}, 32'h3);
    q(esrcu_pkg::OP_EVT_HELD_Q, 1'b1, 8'h0, 32'h0, 32'h1, 8'h0);
    q(esrcu_pkg::OP_EVT_NOW_Q, 1'b1, 8'h0, 32'h0, 32'h1, 8'h0);
    q(esrcu_pkg::OP_EVT_NOW_Q, 1'b1, 8'h10, 32'h0, 32'h0, 8'h0A);
    q(esrcu_pkg::OP_RFORCE_SET, 1'b0, 8'h1, 32'h1, 32'h0, 8'h0);
    w(2);
    chk_pin(relay_drive, 32'h0);
    event_pin = 16'h0000;
    q(esrcu_pkg::OP_RFORCE_SET, 1'b0, 8'h1, 32'h2, 32'h0, 8'h0);
    w(8);
    chk_pin(relay_drive, 32'h1);
    supply_pin = 1'b0;
    w(8);
    chk_pin(relay_drive, 32'h0);
    q(esrcu_pkg::OP_RPOS_Q, 1'b0, 8'h1, 32'h0, 32'h0, 8'h12);
    q(esrcu_pkg::OP_RFORCE_SET, 1'b0, 8'h1, 32'h0, 32'h0, 8'h0);
    q(esrcu_pkg::OP_RFORCE_Q, 1'b0, 8'h1, 32'h0, 32'h0, 8'h0);
    supply_pin = 1'b1;
    w(8);
    q(esrcu_pkg::OP_RPOS_Q, 1'b0, 8'h1, 32'h0, 32'h0, 8'h0);
    q(esrcu_pkg::OP_EVT_HELD_Q, 1'b0, 8'h0, 32'h0, 32'h1, 8'h0);
    w(2);
    chk_pin(event_summary_bit, 32'h0);
    q(esrcu_pkg::OP_FLT_MASK_SET, 1'b0, 8'h0, 32'h8000, 32'h0, 8'h0);
    fault_pin = 16'h8000;
    w(8);
    fault_pin = 16'h0000;
    w(8);
    chk_pin(fault_summary_bit, 32'h1);
    q(esrcu_pkg::OP_FLT_HELD_Q, 1'b0, 8'h0, 32'h0, 32'h8000, 8'h0);
    q(esrcu_pkg::OP_FLT_HELD_Q, 1'b0, 8'h0, 32'h0, 32'h0, 8'h0);
    w(2);
    chk_pin(fault_summary_bit, 32'h0);
    q(esrcu_pkg::OP_TERM_SET, 1'b0, 8'h3, 32'h414243, 32'h0, 8'h0);
    chk_pin({term_len, term_bytes}, {6'h0, 2'h3, 24'h414243});
    // Mid-run reset must bring the terminator back to its default
    rst = 1'b1;
    w(2);
    rst = 1'b0;
    chk_pin({term_len, term_bytes}, {6'h0, 2'h2, 24'h000A0D});
    meas.bad = 4'h1;
    q(esrcu_pkg::OP_NORMALIZED_SOUND_SPEED_QUERY_Q, 1'b0, 8'h0, 32'h0, 32'h7E94F578, 8'h0);
    meas.bad = 4'h0;
    repeat (20) h.send(esrcu_pkg::OP_ERR_POP, 1'b0, 8'h0, 32'h0, un);
    // One more error than the stack holds, so the last one must be lost
    repeat (21) h.send(esrcu_pkg::OP_PURITY_RESULT_QUERY_Q, 1'b0, 8'h0, 32'h0, un);
    q(esrcu_pkg::OP_ERR_POP, 1'b0, 8'h0, 32'h0, 32'hFE, 8'h0);
    repeat (19) q(esrcu_pkg::OP_ERR_POP, 1'b0, 8'h0, 32'h0, 32'h0B, 8'h0);
    q(esrcu_pkg::OP_ERR_POP, 1'b0, 8'h0, 32'h0, 32'h0, 8'h0);
    summarize();
  end
endmodule : event_status_relay_command_unit_tb
